// file: pkg/etg_pkg.sv
/*
 package for the eight-bit timer group: register indices, field positions,
 reset values, prescaler tables and bus carriers.
 assumes an avalon-mm slave with word addressing (index = byte address / 4).
*/
package etg_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PRE_W = 13;

    // register indices
    localparam logic [15:0] OFF_C_MODE = 16'hFFB4;
    localparam logic [15:0] OFF_C_COUNT = 16'hFFB5;
    localparam logic [15:0] OFF_F_CONTROL = 16'hFFB6;
    localparam logic [15:0] OFF_F_STATUS = 16'hFFB7;
    localparam logic [15:0] OFF_FH_COUNT = 16'hFFB8;
    localparam logic [15:0] OFF_FH_COMPARE = 16'hFFBA;
    localparam logic [15:0] OFF_G_MODE = 16'hFFBC;
    localparam logic [15:0] OFF_IRQ_STATUS = 16'hFFA0;
    localparam logic [15:0] OFF_IRQ_MASK = 16'hFFA1;

    // field positions
    localparam int C_RELOAD_SEL_BIT = 7;
    localparam int C_DIR_HW_BIT = 6;
    localparam int C_DIR_DOWN_BIT = 5;
    localparam int C_CKS_LSB = 0;
    localparam int FH_CKS_LSB = 4;
    localparam int F_OVF_BIT = 7;
    localparam int FH_MATCH_BIT = 6;
    localparam int F_OVF_IE_BIT = 5;
    localparam int FH_CLR_BIT = 4;
    localparam int G_OVF_H_BIT = 7;
    localparam int G_OVF_L_BIT = 6;
    localparam int G_OVF_IE_BIT = 5;
    localparam int G_CKS_LSB = 0;
    localparam int IRQ_C_OVF = 0;
    localparam int IRQ_FH_MATCH = 1;
    localparam int IRQ_F_OVF = 2;
    localparam int IRQ_G_OVF = 3;
    localparam int IRQ_N = 4;

    // reset values and masks
    localparam logic [7:0] C_MODE_RST = 8'h00;
    localparam logic [7:0] C_MODE_MASK = 8'hE7;
    localparam logic [7:0] C_COUNT_RST = 8'h00;
    localparam logic [7:0] C_RELOAD_RST = 8'h00;
    localparam logic [7:0] F_CONTROL_RST = 8'h00;
    localparam logic [7:0] FH_COUNT_RST = 8'h00;
    localparam logic [7:0] FH_COMPARE_RST = 8'hFF;
    localparam logic [4:0] G_MODE_LO_RST = 5'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_MIN = 8'h00;

    typedef struct packed {
        logic run;
        logic [3:0] shift;
    } etg_tick_sel_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } etg_av_req_t;

    typedef struct packed {
        logic waitrequest;
        logic [DATA_W-1:0] readdata;
    } etg_av_rsp_t;

    // timer c: 011 is system clock / 64, 11x stops the counter
    function automatic etg_tick_sel_t etg_c_sel(input logic [2:0] code);
        etg_tick_sel_t s;
        s = '{run: 1'b1, shift: 4'hD};
        case (code)
            3'h0: s.shift = 4'hD;
            3'h1: s.shift = 4'hB;
            3'h2: s.shift = 4'h9;
            3'h3: s.shift = 4'h6;
            3'h4: s.shift = 4'h4;
            3'h5: s.shift = 4'h2;
            default: s.run = 1'b0;
        endcase
        return s;
    endfunction

    // timer fh: 110 is system clock / 4, 0xx stops the counter
    function automatic etg_tick_sel_t etg_fh_sel(input logic [2:0] code);
        etg_tick_sel_t s;
        s = '{run: 1'b1, shift: 4'h2};
        case (code)
            3'h4: s.shift = 4'h5;
            3'h5: s.shift = 4'h4;
            3'h6: s.shift = 4'h2;
            3'h7: s.shift = 4'h1;
            default: s.run = 1'b0;
        endcase
        return s;
    endfunction

    // timer g: always running, 00 is system clock / 64
    function automatic etg_tick_sel_t etg_g_sel(input logic [1:0] code);
        etg_tick_sel_t s;
        s = '{run: 1'b1, shift: 4'h6};
        case (code)
            2'h0: s.shift = 4'h6;
            2'h1: s.shift = 4'h5;
            2'h2: s.shift = 4'h3;
            default: s.shift = 4'h1;
        endcase
        return s;
    endfunction

endpackage

// file: rtl/etg_sync.sv
/*
 three-flop synchroniser for a pin input.
 assumes the pin is asynchronous to clk_sys; output moves once stages 2
 and 3 agree.
*/
`timescale 1ns/1ps
module etg_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pin and filtered level
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } etg_sync_state_t;

    etg_sync_state_t state_r;
    etg_sync_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = pin;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        // s1 is only read by s2 to keep metastability off the compare
        if (state_r.s2 == state_r.s3) begin
            state_nxt.q = state_r.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign level = state_r.q;
endmodule

// file: rtl/etg_prescaler.sv
/*
 free-running prescaler giving a one-cycle tick every 2**shift system clocks.
 assumes a select that changes rarely; a change may shorten one period.
*/
`timescale 1ns/1ps
module etg_prescaler (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // divider select and tick
    input etg_pkg::etg_tick_sel_t sel,
    output logic tick
);
    import etg_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        logic tick;
    } etg_pre_state_t;

    etg_pre_state_t state_r;
    etg_pre_state_t state_nxt;
    logic [PRE_W-1:0] mask;

    always_comb begin
        mask = ~({PRE_W{1'b1}} << sel.shift);
        state_nxt = state_r;
        state_nxt.cnt = state_r.cnt + 1'b1;
        state_nxt.tick = sel.run && ((state_r.cnt & mask) == mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign tick = state_r.tick;
endmodule

// file: rtl/etg_top.sv
/*
 eight-bit timer group: timer c (up/down, interval or auto reload),
 timer fh (up-counter with compare and clear on match) and timer g
 overflow flags, reached as an avalon-mm slave with waitrequest.
 assumes a master that holds each request until it sees waitrequest low,
 and pins that are asynchronous to clk_sys.
*/
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module etg_top (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // avalon-mm slave
    input etg_pkg::etg_av_req_t AVS_REQ,
    output etg_pkg::etg_av_rsp_t AVS_RSP,
    // pins
    input wire logic COUNT_DIRECTION_PIN,
    input wire logic CAPTURE_PIN,
    // interrupts
    output logic IRQ,
    output logic IRQ_F_OVERFLOW,
    output logic IRQ_G_OVERFLOW
);
    import etg_pkg::*;

    typedef struct packed {
        logic waitrequest;
        logic [7:0] rdata;
        logic [7:0] c_mode_reg;
        logic [7:0] c_counter;
        logic [7:0] c_reload_value;
        logic [7:0] f_control_reg;
        logic f_overflow_flag;
        logic fh_match_flag;
        logic f_overflow_irq_enable;
        logic fh_clear_on_match;
        logic [7:0] fh_counter;
        logic [7:0] fh_compare_value;
        logic fh_equal_prev;
        logic [7:0] g_counter;
        logic [4:0] g_mode_low;
        logic g_overflow_high_flag;
        logic g_overflow_low_flag;
        logic g_overflow_irq_enable;
        logic [IRQ_N-1:0] irq_status;
        logic [IRQ_N-1:0] irq_mask;
        logic irq;
        logic irq_f;
        logic irq_g;
    } etg_top_state_t;

    localparam etg_top_state_t STATE_RST = '{
        waitrequest: 1'b1,
        rdata: 8'h00,
        c_mode_reg: C_MODE_RST,
        c_counter: C_COUNT_RST,
        c_reload_value: C_RELOAD_RST,
        f_control_reg: F_CONTROL_RST,
        f_overflow_flag: 1'b0,
        fh_match_flag: 1'b0,
        f_overflow_irq_enable: 1'b0,
        fh_clear_on_match: 1'b0,
        fh_counter: FH_COUNT_RST,
        fh_compare_value: FH_COMPARE_RST,
        fh_equal_prev: 1'b0,
        g_counter: 8'h00,
        g_mode_low: G_MODE_LO_RST,
        g_overflow_high_flag: 1'b0,
        g_overflow_low_flag: 1'b0,
        g_overflow_irq_enable: 1'b0,
        irq_status: '0,
        irq_mask: IRQ_MASK_RST,
        irq: 1'b0,
        irq_f: 1'b0,
        irq_g: 1'b0
    };

    etg_top_state_t state_r;
    etg_top_state_t state_nxt;

    logic dir_pin_level;
    logic capture_level;
    logic c_tick;
    logic fh_tick;
    logic g_tick;
    etg_tick_sel_t c_sel;
    etg_tick_sel_t fh_sel;
    etg_tick_sel_t g_sel;

    // prescaler selects come straight from the mode registers
    assign c_sel = etg_c_sel(state_r.c_mode_reg[C_CKS_LSB+:3]);
    assign fh_sel = etg_fh_sel(state_r.f_control_reg[FH_CKS_LSB+:3]);
    assign g_sel = etg_g_sel(state_r.g_mode_low[G_CKS_LSB+:2]);

    etg_sync u_sync_dir (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .pin(COUNT_DIRECTION_PIN),
        .level(dir_pin_level)
    );

    etg_sync u_sync_cap (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .pin(CAPTURE_PIN),
        .level(capture_level)
    );

    etg_prescaler u_pre_c (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .sel(c_sel),
        .tick(c_tick)
    );

    etg_prescaler u_pre_fh (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .sel(fh_sel),
        .tick(fh_tick)
    );

    etg_prescaler u_pre_g (
        .clk_sys(CLK_SYS),
        .rst(RST),
        .sel(g_sel),
        .tick(g_tick)
    );

    // register read mux, reserved bits read zero except f_control_reg bits 7 and 3:0 and g_mode_low bits 4:2, which read back as written
    function automatic logic [7:0] read_mux(input etg_top_state_t s,
                                            input logic [ADDR_W-1:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            OFF_C_MODE: d = s.c_mode_reg;
            OFF_C_COUNT: d = s.c_counter;
            OFF_F_CONTROL: d = s.f_control_reg;
            OFF_F_STATUS: begin
                d[F_OVF_BIT] = s.f_overflow_flag;
                d[FH_MATCH_BIT] = s.fh_match_flag;
                d[F_OVF_IE_BIT] = s.f_overflow_irq_enable;
                d[FH_CLR_BIT] = s.fh_clear_on_match;
            end
            OFF_FH_COUNT: d = s.fh_counter;
            OFF_FH_COMPARE: d = s.fh_compare_value;
            OFF_G_MODE: begin
                d[4:0] = s.g_mode_low;
                d[G_OVF_H_BIT] = s.g_overflow_high_flag;
                d[G_OVF_L_BIT] = s.g_overflow_low_flag;
                d[G_OVF_IE_BIT] = s.g_overflow_irq_enable;
            end
            OFF_IRQ_STATUS: d[IRQ_N-1:0] = s.irq_status;
            OFF_IRQ_MASK: d[IRQ_N-1:0] = s.irq_mask;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb begin
        logic access;
        logic take;
        logic wr;
        logic [7:0] wd;
        logic wr_c_mode;
        logic wr_c_count;
        logic wr_f_control;
        logic wr_f_status;
        logic wr_fh_count;
        logic wr_fh_compare;
        logic wr_g_mode;
        logic wr_irq_status;
        logic wr_irq_mask;
        logic c_down;
        logic c_ovf;
        logic fh_equal;
        logic fh_match_evt;
        logic f_ovf;
        logic g_ovf;
        logic [IRQ_N-1:0] events;
        access = 1'b0;
        take = 1'b0;
        wr = 1'b0;
        wd = 8'h00;
        wr_c_mode = 1'b0;
        wr_c_count = 1'b0;
        wr_f_control = 1'b0;
        wr_f_status = 1'b0;
        wr_fh_count = 1'b0;
        wr_fh_compare = 1'b0;
        wr_g_mode = 1'b0;
        wr_irq_status = 1'b0;
        wr_irq_mask = 1'b0;
        c_down = 1'b0;
        c_ovf = 1'b0;
        fh_equal = 1'b0;
        fh_match_evt = 1'b0;
        f_ovf = 1'b0;
        g_ovf = 1'b0;
        events = '0;
        state_nxt = state_r;

        // bus: one wait cycle, then the request is taken with waitrequest low
        access = AVS_REQ.read || AVS_REQ.write;
        take = access && !state_r.waitrequest;
        wr = AVS_REQ.write && take;
        wd = AVS_REQ.writedata[7:0];
        // one strobe per register, high only on the edge a write is taken
        wr_c_mode = wr && AVS_REQ.address == OFF_C_MODE;
        wr_c_count = wr && AVS_REQ.address == OFF_C_COUNT;
        wr_f_control = wr && AVS_REQ.address == OFF_F_CONTROL;
        wr_f_status = wr && AVS_REQ.address == OFF_F_STATUS;
        wr_fh_count = wr && AVS_REQ.address == OFF_FH_COUNT;
        wr_fh_compare = wr && AVS_REQ.address == OFF_FH_COMPARE;
        wr_g_mode = wr && AVS_REQ.address == OFF_G_MODE;
        wr_irq_status = wr && AVS_REQ.address == OFF_IRQ_STATUS;
        wr_irq_mask = wr && AVS_REQ.address == OFF_IRQ_MASK;
        if (access && state_r.waitrequest) begin
            state_nxt.waitrequest = 1'b0;
            state_nxt.rdata = read_mux(state_r, AVS_REQ.address);
        end else begin
            state_nxt.waitrequest = 1'b1;
        end

        // timer c
        if (state_r.c_mode_reg[C_DIR_HW_BIT]) begin
            c_down = dir_pin_level;
        end else begin
            c_down = state_r.c_mode_reg[C_DIR_DOWN_BIT];
        end
        if (wr_c_mode) begin
            state_nxt.c_mode_reg = wd & C_MODE_MASK;
        end
        if (wr_c_count) begin
            state_nxt.c_reload_value = wd;
            state_nxt.c_counter = wd;
        end else if (c_tick) begin
            if (c_down) begin
                c_ovf = state_r.c_counter == CNT_MIN;
                state_nxt.c_counter = state_r.c_counter - 8'h01;
            end else begin
                c_ovf = state_r.c_counter == CNT_MAX;
                state_nxt.c_counter = state_r.c_counter + 8'h01;
            end
            // interval mode simply wraps; reload mode restarts from the value
            if (c_ovf && state_r.c_mode_reg[C_RELOAD_SEL_BIT]) begin
                state_nxt.c_counter = state_r.c_reload_value;
            end
        end

        // timer fh
        fh_equal = state_r.fh_counter == state_r.fh_compare_value;
        // only the first cycle of equality counts, so a cleared flag
        // is not set again while the counter rests on the compare value
        fh_match_evt = fh_equal && !state_r.fh_equal_prev;
        state_nxt.fh_equal_prev = fh_equal;
        if (wr_f_control) begin
            state_nxt.f_control_reg = wd;
        end
        if (wr_fh_compare) begin
            state_nxt.fh_compare_value = wd;
        end
        if (wr_fh_count) begin
            state_nxt.fh_counter = wd;
        end else if (fh_tick) begin
            if (fh_equal && state_r.fh_clear_on_match) begin
                state_nxt.fh_counter = CNT_MIN;
            end else begin
                f_ovf = state_r.fh_counter == CNT_MAX;
                state_nxt.fh_counter = state_r.fh_counter + 8'h01;
            end
        end
        if (wr_f_status) begin
            state_nxt.f_overflow_flag = state_r.f_overflow_flag &
                                        wd[F_OVF_BIT];
            state_nxt.fh_match_flag = state_r.fh_match_flag &
                                      wd[FH_MATCH_BIT];
            state_nxt.f_overflow_irq_enable = wd[F_OVF_IE_BIT];
            state_nxt.fh_clear_on_match = wd[FH_CLR_BIT];
        end
        // set wins over a clear written in the same cycle
        if (f_ovf) begin
            state_nxt.f_overflow_flag = 1'b1;
        end
        if (fh_match_evt) begin
            state_nxt.fh_match_flag = 1'b1;
        end

        // timer g overflow only
        if (g_tick) begin
            g_ovf = state_r.g_counter == CNT_MAX;
            state_nxt.g_counter = state_r.g_counter + 8'h01;
        end
        if (wr_g_mode) begin
            state_nxt.g_overflow_high_flag = state_r.g_overflow_high_flag &
                                             wd[G_OVF_H_BIT];
            state_nxt.g_overflow_low_flag = state_r.g_overflow_low_flag &
                                            wd[G_OVF_L_BIT];
            state_nxt.g_overflow_irq_enable = wd[G_OVF_IE_BIT];
            state_nxt.g_mode_low = wd[4:0];
        end
        if (g_ovf && capture_level) begin
            state_nxt.g_overflow_high_flag = 1'b1;
        end
        if (g_ovf && !capture_level) begin
            state_nxt.g_overflow_low_flag = 1'b1;
        end

        // summary interrupt: sticky status, write one to clear, set wins
        events[IRQ_C_OVF] = c_tick && c_ovf &&
                            !wr_c_count;
        events[IRQ_FH_MATCH] = fh_match_evt;
        events[IRQ_F_OVF] = f_ovf;
        events[IRQ_G_OVF] = g_ovf;
        if (wr_irq_status) begin
            state_nxt.irq_status = state_r.irq_status & ~wd[IRQ_N-1:0];
        end
        if (wr_irq_mask) begin
            state_nxt.irq_mask = wd[IRQ_N-1:0];
        end
        state_nxt.irq_status = state_nxt.irq_status | events;
        state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);

        // request lines follow next flag and enable so the flop adds no lag
        state_nxt.irq_f = state_nxt.f_overflow_flag &&
                          state_nxt.f_overflow_irq_enable;
        state_nxt.irq_g = (state_nxt.g_overflow_high_flag ||
                           state_nxt.g_overflow_low_flag) &&
                          state_nxt.g_overflow_irq_enable;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r <= STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign AVS_RSP.waitrequest = state_r.waitrequest;
    assign AVS_RSP.readdata = {24'h000000, state_r.rdata};
    assign IRQ = state_r.irq;
    assign IRQ_F_OVERFLOW = state_r.irq_f;
    assign IRQ_G_OVERFLOW = state_r.irq_g;
endmodule

// file: tb/etg_top_asserts.sv
/*
 checker for etg_top: bus answer timing, flag clearing and irq outputs.
 assumes it is bound to etg_top and sees only the top module's ports.
*/
`timescale 1ns/1ps
module etg_top_asserts (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // avalon-mm slave
    input etg_pkg::etg_av_req_t AVS_REQ,
    input etg_pkg::etg_av_rsp_t AVS_RSP,
    // interrupts
    input wire logic IRQ,
    input wire logic IRQ_F_OVERFLOW,
    input wire logic IRQ_G_OVERFLOW
);
    import etg_pkg::*;
    logic take_wr;
    logic wr_fs;
    logic wr_g;
    logic wr_irq;
    logic wr_mask0;
    assign take_wr = AVS_REQ.write && !AVS_RSP.waitrequest;
    assign wr_fs = take_wr && AVS_REQ.address == OFF_F_STATUS;
    assign wr_g = take_wr && AVS_REQ.address == OFF_G_MODE;
    assign wr_irq = take_wr && (AVS_REQ.address == OFF_IRQ_STATUS
        || AVS_REQ.address == OFF_IRQ_MASK);
    assign wr_mask0 = take_wr && AVS_REQ.address == OFF_IRQ_MASK
        && AVS_REQ.writedata[3:0] == 4'h0;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_req_wait;
        (AVS_REQ.read || AVS_REQ.write) && AVS_RSP.waitrequest;
    endsequence
    // the answer is a single low cycle, so a held request is taken once
    sequence s_answer;
        !AVS_RSP.waitrequest ##1 AVS_RSP.waitrequest;
    endsequence
    AST_BUS_ANSWER: assert property (s_req_wait |=> s_answer)
        else $error("bus answer is not one cycle");
    AST_RD_UPPER: assert property (AVS_REQ.read && !AVS_RSP.waitrequest
        |-> AVS_RSP.readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_RD_UNMAPPED: assert property (AVS_REQ.read && !AVS_RSP.waitrequest
        && AVS_REQ.address == 16'h0000 |-> AVS_RSP.readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_F_IE_OFF: assert property (
        wr_fs && !AVS_REQ.writedata[F_OVF_IE_BIT] |=> !IRQ_F_OVERFLOW)
        else $error("f overflow request with enable off");
    AST_G_IE_OFF: assert property (
        wr_g && !AVS_REQ.writedata[G_OVF_IE_BIT] |=> !IRQ_G_OVERFLOW)
        else $error("g overflow request with enable off");
    AST_MASK_OFF: assert property (wr_mask0 |=> !IRQ)
        else $error("irq high with mask cleared");
    AST_F_HOLD: assert property (
        $fell(IRQ_F_OVERFLOW) |-> $past(wr_fs))
        else $error("f overflow request dropped without write");
    AST_G_HOLD: assert property (
        $fell(IRQ_G_OVERFLOW) |-> $past(wr_g))
        else $error("g overflow request dropped without write");
    AST_IRQ_HOLD: assert property ($fell(IRQ) |-> $past(wr_irq))
        else $error("irq dropped without status or mask write");
endmodule

// file: tb/etg_top_tb.sv
/*
 self-checking bench for etg_top: register access, timer rates, reload,
 flags and interrupt outputs through avalon-mm calls.
 assumes the checker file is compiled first; bound at the foot.
*/
`timescale 1ns/1ps
module etg_top_tb;
    import etg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    etg_av_req_t req = '0;
    etg_av_rsp_t rsp;
    logic dir_pin = 1'b0;
    logic cap_pin = 1'b0;
    logic irq;
    logic irq_f;
    logic irq_g;
    int bad_count = 0;
    int tests_run = 0;
    int i;
    logic [7:0] v;
    logic [7:0] dv;
    logic [15:0] ra [10] = '{16'hFFB4, 16'hFFB5, 16'hFFB6, 16'hFFB7,
        16'hFFB8, 16'hFFBA, 16'hFFBC, 16'hFFA0, 16'hFFA1, 16'h0000};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] cm [4] = '{8'h03, 8'h23, 8'h43, 8'h43};
    logic [7:0] ce [4] = '{8'h0A, 8'hF6, 8'h0A, 8'hF6};

    always #4 clk_sys = ~clk_sys;

    etg_top u_dut (.CLK_SYS(clk_sys), .RST(rst), .AVS_REQ(req),
        .AVS_RSP(rsp), .COUNT_DIRECTION_PIN(dir_pin),
        .CAPTURE_PIN(cap_pin), .IRQ(irq), .IRQ_F_OVERFLOW(irq_f),
        .IRQ_G_OVERFLOW(irq_g));

    task check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // an idle edge after release keeps back-to-back calls race free
    task access(input logic rd, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{read: rd, write: !rd, address: a, writedata: {24'h0, d}};
        @(posedge clk_sys);
        while (rsp.waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 20) begin
            check(8'h00, 8'h01);
            give_verdict();
        end
        v = rsp.readdata[7:0];
        req <= '0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        access(1'b0, a, d);
    endtask

    task rd(input logic [15:0] a);
        access(1'b1, a, 8'h00);
    endtask

    // snapshots lie k+3 cycles apart, so any prescaler phase gives one count
    task rate(input logic [15:0] a, input int k, output logic [7:0] d);
        logic [7:0] x;
        rd(a);
        x = v;
        repeat (k) @(posedge clk_sys);
        rd(a);
        d = v - x;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        check(8'h00, 8'h01);
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        wr(16'h0000, 8'hFF);
        for (i = 0; i < 10; i++) begin
            rd(ra[i]);
            check(v, rv[i]);
        end
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            dir_pin <= (i == 3);
            wr(OFF_C_MODE, cm[i]);
            repeat (70) @(posedge clk_sys);
            rate(OFF_C_COUNT, 637, dv);
            check(dv, ce[i]);
        end
        wr(OFF_C_COUNT, 8'hFC);
        wr(OFF_C_MODE, 8'h03);
        repeat (400) @(posedge clk_sys);
        rd(OFF_C_COUNT);
        check({7'h00, v < 8'hFC}, 8'h01);
        wr(OFF_C_MODE, 8'h83);
        wr(OFF_C_COUNT, 8'hFC);
        rd(OFF_C_COUNT);
        check({7'h00, v < 8'hFE && v > 8'hFB}, 8'h01);
        for (i = 0; i < 4; i++) begin
            repeat (100) @(posedge clk_sys);
            rd(OFF_C_COUNT);
            check({7'h00, v > 8'hFB}, 8'h01);
        end
        $display("test timer c done");
        rd(OFF_IRQ_STATUS);
        check(v & 8'h01, 8'h01);
        wr(OFF_IRQ_MASK, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_C_MODE, 8'h06);
        wr(OFF_IRQ_STATUS, 8'h0F);
        check({7'h00, irq}, 8'h00);
        rd(OFF_IRQ_STATUS);
        check(v & 8'h01, 8'h00);
        $display("test interrupts done");
        wr(OFF_F_CONTROL, 8'h60);
        rate(OFF_FH_COUNT, 125, dv);
        check(dv, 8'h20);
        wr(OFF_FH_COMPARE, 8'h10);
        wr(OFF_F_STATUS, 8'h10);
        wr(OFF_FH_COUNT, 8'h00);
        for (i = 0; i < 6; i++) begin
            repeat (30) @(posedge clk_sys);
            rd(OFF_FH_COUNT);
            check({7'h00, v <= 8'h10}, 8'h01);
        end
        rd(OFF_F_STATUS);
        check(v, 8'h50);
        $display("test timer fh done");
        wr(OFF_F_CONTROL, 8'h00);
        wr(OFF_F_STATUS, 8'h20);
        wr(OFF_FH_COMPARE, 8'hFF);
        wr(OFF_FH_COUNT, 8'hF0);
        wr(OFF_F_CONTROL, 8'h70);
        repeat (60) @(posedge clk_sys);
        check({7'h00, irq_f}, 8'h01);
        wr(OFF_F_CONTROL, 8'h00);
        wr(OFF_F_STATUS, 8'hC0);
        check({7'h00, irq_f}, 8'h00);
        rd(OFF_F_STATUS);
        check(v, 8'hC0);
        wr(OFF_F_STATUS, 8'h60);
        rd(OFF_F_STATUS);
        check(v, 8'h60);
        check({7'h00, irq_f}, 8'h00);
        $display("test timer f done");
        cap_pin <= 1'b1;
        wr(OFF_G_MODE, 8'h23);
        for (i = 0; i < 700 && irq_g !== 1'b1; i++) @(posedge clk_sys);
        rd(OFF_G_MODE);
        check(v, 8'hA3);
        wr(OFF_G_MODE, 8'h23);
        check({7'h00, irq_g}, 8'h00);
        cap_pin <= 1'b0;
        for (i = 0; i < 700 && irq_g !== 1'b1; i++) @(posedge clk_sys);
        rd(OFF_G_MODE);
        check(v, 8'h63);
        wr(OFF_G_MODE, 8'hC3);
        check({7'h00, irq_g}, 8'h00);
        rd(OFF_G_MODE);
        check(v, 8'h43);
        $display("test timer g done");
        give_verdict();
    end
endmodule

bind etg_top etg_top_asserts u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .AVS_REQ(AVS_REQ), .AVS_RSP(AVS_RSP), .IRQ(IRQ),
    .IRQ_F_OVERFLOW(IRQ_F_OVERFLOW), .IRQ_G_OVERFLOW(IRQ_G_OVERFLOW));
